// file: hdl/lal_pkg.sv
// Purpose: Constants and types for the LED annunciator logic.
// Assumes: One clock, word-indexed register port, sources from logic on the same clock.
// Notes: Register word index = {led number, register select}.
package lal_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Sizes
    localparam int SLOTS = 5;
    localparam int SEL_W = 5;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int LED_IDX_W = 6;

    ////////////////////////////////////////////////////////////////////////////
    // Register select within one LED's group of four words
    localparam logic [1:0] REG_CFG = 2'h0;
    localparam logic [1:0] REG_ASGN = 2'h1;
    localparam logic [1:0] REG_STAT = 2'h2;

    // Status word bit positions
    localparam int STAT_OR = 0;
    localparam int STAT_LATCH = 1;
    localparam int STAT_ACTIVE = 2;
    localparam int STAT_RED = 3;
    localparam int STAT_GREEN = 4;

    ////////////////////////////////////////////////////////////////////////////
    // Blink timing
    localparam int CLK_HZ = 25_000_000;
    localparam int BLINK_HALF_MS = 500;
    localparam int BLINK_HALF_CYC = CLK_HZ / 1000 * BLINK_HALF_MS;

    ////////////////////////////////////////////////////////////////////////////
    // Encodings
    typedef enum logic [1:0] {
        LAL_LATCH_OFF,
        LAL_LATCH_ACK_SIG,
        LAL_LATCH_ACK_ALARM,
        LAL_LATCH_RSVD
    } lal_latch_e;

    typedef enum logic [1:0] {
        LAL_COL_GREEN,
        LAL_COL_RED,
        LAL_COL_RED_FLASH,
        LAL_COL_GREEN_FLASH
    } lal_col_e;

    // Config word: [1:0] latch, [3:2] active, [5:4] inactive, [6] enable,
    // [11:7] invert mask, [16:12] acknowledge source
    typedef struct packed {
        logic [SEL_W-1:0] ack_sel;
        logic [SLOTS-1:0] inv;
        logic en;
        lal_col_e inact;
        lal_col_e act;
        lal_latch_e latch;
    } lal_cfg_s;

    // Assignment word: [24:0] five source indices, [29:25] slot used flags
    typedef struct packed {
        logic [SLOTS-1:0] used;
        logic [SLOTS-1:0][SEL_W-1:0] sel;
    } lal_asgn_s;

    localparam int CFG_W = $bits(lal_cfg_s);
    localparam int ASGN_W = $bits(lal_asgn_s);

    // Reset: LED dark, not latched, no inversion, no slot assigned
    localparam lal_cfg_s CFG_RST = '{ack_sel: '0, inv: '0, en: 1'b0,
                                     inact: LAL_COL_GREEN, act: LAL_COL_GREEN,
                                     latch: LAL_LATCH_OFF};
    localparam lal_asgn_s ASGN_RST = '{used: '0, sel: '0};

endpackage : lal_pkg

// file: hdl/lal_top.sv
// Purpose: Per-LED OR annunciation with inversion, colours, blink and latching.
// Assumes: src_i and alarm_ack_i come from logic on clk_i, so no synchroniser.
// Notes: Register port is word indexed; read data valid only in the cycle after rd_i.
`timescale 1ns/1ns
`default_nettype none

module lal_top #(
    parameter int N_LED = 6,
    parameter int N_SRC = 32,
    parameter int BLINK_HALF_CYC = lal_pkg::BLINK_HALF_CYC
) (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic en_i,
    // Internal status sources
    input wire logic [N_SRC-1:0] src_i,
    input wire logic alarm_ack_i,
    // Register port
    input wire logic [lal_pkg::ADDR_W-1:0] addr_i,
    input wire logic [lal_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [lal_pkg::DATA_W-1:0] rdata_o,
    // Bicolour LED drive
    output logic [N_LED-1:0] led_red_o,
    output logic [N_LED-1:0] led_green_o
);

    localparam int CNT_W = $clog2(BLINK_HALF_CYC + 1);

    ////////////////////////////////////////////////////////////////////////////
    // Elaboration checks
    if (N_LED < 1 || N_LED > (1 << lal_pkg::LED_IDX_W)) begin : g_chk_led
        $error("N_LED out of range");
    end
    if (N_SRC < 1 || N_SRC > (1 << lal_pkg::SEL_W)) begin : g_chk_src
        $error("N_SRC out of range");
    end
    if (BLINK_HALF_CYC < 1) begin : g_chk_blink
        $error("BLINK_HALF_CYC must be at least one");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Source selection, shared by slots and acknowledge
    function automatic logic lal_pick(input logic [N_SRC-1:0] v, input logic [lal_pkg::SEL_W-1:0] s);
        logic r;
        r = 1'b0;
        for (int k = 0; k < N_SRC; k++) begin
            if (s == lal_pkg::SEL_W'(k)) begin
                r = v[k];
            end
        end
        return r;
    endfunction : lal_pick

    function automatic logic [1:0] lal_drive(input lal_pkg::lal_col_e c, input logic ph);
        logic [1:0] rg;
        rg = 2'b00;
        unique case (c)
            lal_pkg::LAL_COL_GREEN: rg = 2'b01;
            lal_pkg::LAL_COL_RED: rg = 2'b10;
            lal_pkg::LAL_COL_RED_FLASH: rg = {ph, 1'b0};
            lal_pkg::LAL_COL_GREEN_FLASH: rg = {1'b0, ph};
        endcase
        return rg;
    endfunction : lal_drive

    ////////////////////////////////////////////////////////////////////////////
    // State
    lal_pkg::lal_cfg_s cfg [N_LED];
    lal_pkg::lal_cfg_s next_cfg [N_LED];
    lal_pkg::lal_asgn_s asgn [N_LED];
    lal_pkg::lal_asgn_s next_asgn [N_LED];
    logic [N_LED-1:0] latched;
    logic [N_LED-1:0] next_latched;
    logic [N_LED-1:0] or_res;
    logic [N_LED-1:0] shown;
    logic [N_LED-1:0] next_red;
    logic [N_LED-1:0] next_green;
    logic [CNT_W-1:0] blink_cnt;
    logic [CNT_W-1:0] next_blink_cnt;
    logic blink_ph;
    logic next_blink_ph;
    logic [lal_pkg::DATA_W-1:0] next_rdata;

    logic [lal_pkg::LED_IDX_W-1:0] acc_led;
    logic [1:0] acc_reg;
    logic acc_hit;

    assign acc_led = addr_i[lal_pkg::ADDR_W-1:2];
    assign acc_reg = addr_i[1:0];
    assign acc_hit = ({1'b0, acc_led} < (lal_pkg::LED_IDX_W + 1)'(N_LED));

    ////////////////////////////////////////////////////////////////////////////
    // Shared blink phase; one counter so every flashing LED is in step
    always_comb begin
        next_blink_cnt = blink_cnt + CNT_W'(1);
        next_blink_ph = blink_ph;
        if (blink_cnt == CNT_W'(BLINK_HALF_CYC - 1)) begin
            next_blink_cnt = '0;
            next_blink_ph = ~blink_ph;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            blink_cnt <= '0;
            blink_ph <= 1'b0;
        end else if (en_i) begin
            blink_cnt <= next_blink_cnt;
            blink_ph <= next_blink_ph;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-LED evaluation
    for (genvar i = 0; i < N_LED; i++) begin : g_led
        logic [lal_pkg::SLOTS-1:0] term;
        logic ack;
        logic [1:0] rg;

        for (genvar j = 0; j < lal_pkg::SLOTS; j++) begin : g_slot
            // Unassigned slot gives false whatever its invert bit
            assign term[j] = asgn[i].used[j] & (lal_pick(src_i, asgn[i].sel[j]) ^ cfg[i].inv[j]);
        end

        assign or_res[i] = |term;

        always_comb begin
            ack = 1'b0;
            next_latched[i] = 1'b0;
            unique case (cfg[i].latch)
                lal_pkg::LAL_LATCH_ACK_SIG: ack = lal_pick(src_i, cfg[i].ack_sel);
                lal_pkg::LAL_LATCH_ACK_ALARM: ack = alarm_ack_i;
                default: ack = 1'b0;
            endcase
            if (cfg[i].latch == lal_pkg::LAL_LATCH_ACK_SIG || cfg[i].latch == lal_pkg::LAL_LATCH_ACK_ALARM) begin
                // Pickup beats acknowledge, so a live cause keeps the latch
                next_latched[i] = or_res[i] | (latched[i] & ~ack);
            end
        end

        assign shown[i] = or_res[i] | latched[i];
        assign rg = lal_drive(shown[i] ? cfg[i].act : cfg[i].inact, blink_ph);
        assign next_red[i] = cfg[i].en & rg[1];
        assign next_green[i] = cfg[i].en & rg[0];
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            latched <= '0;
            led_red_o <= '0;
            led_green_o <= '0;
        end else if (en_i) begin
            latched <= next_latched;
            led_red_o <= next_red;
            led_green_o <= next_green;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register writes
    always_comb begin
        for (int n = 0; n < N_LED; n++) begin
            next_cfg[n] = cfg[n];
            next_asgn[n] = asgn[n];
            if (wr_i && acc_hit && acc_led == lal_pkg::LED_IDX_W'(n)) begin
                if (acc_reg == lal_pkg::REG_CFG) begin
                    next_cfg[n] = lal_pkg::lal_cfg_s'(wdata_i[lal_pkg::CFG_W-1:0]);
                end
                if (acc_reg == lal_pkg::REG_ASGN) begin
                    next_asgn[n] = lal_pkg::lal_asgn_s'(wdata_i[lal_pkg::ASGN_W-1:0]);
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (int n = 0; n < N_LED; n++) begin
                cfg[n] <= lal_pkg::CFG_RST;
                asgn[n] <= lal_pkg::ASGN_RST;
            end
        end else if (en_i) begin
            for (int n = 0; n < N_LED; n++) begin
                cfg[n] <= next_cfg[n];
                asgn[n] <= next_asgn[n];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register reads; unmapped words and idle cycles read zero
    always_comb begin
        next_rdata = '0;
        if (rd_i && acc_hit) begin
            for (int n = 0; n < N_LED; n++) begin
                if (acc_led == lal_pkg::LED_IDX_W'(n)) begin
                    unique case (acc_reg)
                        lal_pkg::REG_CFG: next_rdata[lal_pkg::CFG_W-1:0] = cfg[n];
                        lal_pkg::REG_ASGN: next_rdata[lal_pkg::ASGN_W-1:0] = asgn[n];
                        lal_pkg::REG_STAT: begin
                            next_rdata[lal_pkg::STAT_OR] = or_res[n];
                            next_rdata[lal_pkg::STAT_LATCH] = latched[n];
                            next_rdata[lal_pkg::STAT_ACTIVE] = shown[n];
                            next_rdata[lal_pkg::STAT_RED] = led_red_o[n];
                            next_rdata[lal_pkg::STAT_GREEN] = led_green_o[n];
                        end
                        default: next_rdata = '0;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_o <= '0;
        end else if (en_i) begin
            rdata_o <= next_rdata;
        end
    end

endmodule : lal_top

`default_nettype wire

// file: tb/lal_led_model.sv
// Purpose: Front-panel bicolour LED seen by an observer.
// Assumes: Drive lines sampled on the system clock.
// Notes: Counts turn-on events so the flash rate can be judged.
`timescale 1ns/1ns
`default_nettype none
module lal_led_model (
    // Clock
    input wire logic clk_i,
    // Element drive
    input wire logic red_i,
    input wire logic green_i,
    // Observation
    output var int lit_rises_o
);
    logic lit_q = 1'b0;
    int rises_q = 0;
    // One driver for the count; the port only mirrors it
    assign lit_rises_o = rises_q;
    always @(posedge clk_i) begin
        lit_q <= red_i | green_i;
        if ((red_i | green_i) && !lit_q) begin
            rises_q <= rises_q + 1;
        end
    end
endmodule : lal_led_model
`default_nettype wire

// file: tb/lal_sva.sv
// Purpose: Port assertions for the LED annunciator.
// Assumes: LED 0 set-up is shadowed from register writes.
// Notes: Only LED 0 is checked in depth.
`timescale 1ns/1ns
`default_nettype none
module lal_sva #(
    parameter int N_LED = 6,
    parameter int N_SRC = 32,
    parameter int BLINK_HALF_CYC = 4
) (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic en_i,
    // Sources
    input wire logic [N_SRC-1:0] src_i,
    input wire logic alarm_ack_i,
    // Register port
    input wire logic [lal_pkg::ADDR_W-1:0] addr_i,
    input wire logic [lal_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [lal_pkg::DATA_W-1:0] rdata_o,
    // LED drive
    input wire logic [N_LED-1:0] led_red_o,
    input wire logic [N_LED-1:0] led_green_o
);
    logic [31:0] c0;
    logic [31:0] a0;
    logic or0;
    wire ack0 = src_i[c0[16:12]];
    // Red active, green inactive, plain latch and alarm latch
    wire m1 = c0[6] && c0[5:0] == 6'h05;
    wire m2 = c0[6] && c0[5:0] == 6'h06;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            c0 <= '0;
            a0 <= '0;
        end else if (en_i && wr_i && addr_i == 8'h00) begin
            c0 <= wdata_i;
        end else if (en_i && wr_i && addr_i == 8'h01) begin
            a0 <= wdata_i;
        end
    end
    always_comb begin
        or0 = 1'b0;
        for (int j = 0; j < 5; j++) begin
            or0 = or0 | (a0[25+j] & (src_i[a0[5*j+:5]] ^ c0[7+j]));
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking dc @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    a_one_colour: assert property (!(|(led_red_o & led_green_o)))
        else $error("both elements lit");
    a_en_freeze: assert property (!en_i |=> $stable(led_red_o) && $stable(led_green_o))
        else $error("outputs moved while disabled");
    a_rdata_idle: assert property ($past(en_i) && !$past(rd_i) |-> rdata_o == '0)
        else $error("read data outside read slot");
    a_act_colour: assert property (en_i && c0[6] && c0[3:0] == 4'h4 && or0 |=> led_red_o[0] && !led_green_o[0])
        else $error("active colour missing");
    a_inact_colour: assert property (en_i && c0[6] && c0[5:4] == 2'h0 && c0[1:0] == 2'h0 && !or0 |=> led_green_o[0])
        else $error("inactive colour missing");
    a_latch_hold: assert property (en_i && m1 && or0 ##1 en_i && m1 && !ack0 |=> led_red_o[0])
        else $error("latch dropped");
    a_ack_clear: assert property (en_i && m1 && !or0 && ack0 ##1 en_i && m1 && !or0 |=> led_green_o[0])
        else $error("acknowledge did not clear");
    a_ack_blocked: assert property (en_i && m1 && or0 && ack0 ##1 en_i && m1 && !or0 && !ack0 |=> led_red_o[0])
        else $error("acknowledge taken while source up");
    a_alarm_only: assert property (en_i && m2 && or0 ##1 en_i && m2 && !alarm_ack_i |=> led_red_o[0])
        else $error("selected source cleared alarm latch");
    c_latched: cover property (m1 && or0 ##1 m1 && !or0);
    c_cleared: cover property (m1 && !or0 && ack0);
    c_alarm: cover property (m2 && alarm_ack_i);
endmodule : lal_sva
`default_nettype wire

// file: tb/lal_top_bench.sv
// Purpose: Self-checking bench for the LED annunciator.
// Assumes: Blink half period cut to BH cycles to keep the run short.
// Notes: LED 0 carries the checks; LED 1 flashes beside it.
`timescale 1ns/1ns
`default_nettype none
module lal_top_bench;
    localparam int BH = 4;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic en_i = 1'b1;
    logic alarm_ack_i = 1'b0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [31:0] src_i = 32'h0;
    logic [31:0] wdata_i = 32'h0;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] rdata_o;
    logic [5:0] led_red_o;
    logic [5:0] led_green_o;
    int miscompares = 0;
    int compares = 0;
    int cyc = 0;
    int rises;
    logic [31:0] r0;
    lal_top #(.BLINK_HALF_CYC(BH)) dut (.clk_i, .rst_b_i, .en_i, .src_i, .alarm_ack_i, .addr_i, .wdata_i,
        .wr_i, .rd_i, .rdata_o, .led_red_o, .led_green_o);
    lal_led_model led0 (.clk_i, .red_i(led_red_o[0]), .green_i(led_green_o[0]), .lit_rises_o(rises));
    initial forever #20 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            miscompares++;
            summarize();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        // Strobe drops for one edge so a following write never reassigns it in one step
        wr_i <= 1'b0;
        @(posedge clk_i);
    endtask : wr
    // Read data stand only one cycle, so they are taken mid-cycle
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(negedge clk_i);
        chk(rdata_o, e);
        @(posedge clk_i);
    endtask : rd
    task automatic cl(input logic [1:0] e);
        @(posedge clk_i);
        @(negedge clk_i);
        chk({30'h0, led_red_o[0], led_green_o[0]}, {30'h0, e});
        @(posedge clk_i);
    endtask : cl
    function automatic logic [31:0] cfg(input logic [1:0] l, input logic [1:0] act, input logic [1:0] ina,
        input logic [4:0] inv, input logic [4:0] ack);
        return {15'h0000, ack, inv, 1'b1, ina, act, l};
    endfunction : cfg
    task automatic summarize;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : summarize
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        r0 = $urandom(32'h45A0AB1B);
        repeat (4) @(posedge clk_i);
        rst_b_i <= 1'b1;
        @(posedge clk_i);
        rd(8'h00, 32'h0);
        rd(8'h01, 32'h0);
        cl(2'h0);
        r0 = $urandom;
        wr(8'h04, r0);
        rd(8'h04, {15'h0000, r0[16:0]});
        wr(8'h18, 32'hFFFFFFFF);
        rd(8'h18, 32'h0);
        wr(8'h02, 32'hFFFFFFFF);
        rd(8'h02, 32'h0);
        rd(8'h07, 32'h0);
        wr(8'h04, 32'h0);
        $display("test registers done");
        wr(8'h01, 32'h02000003);
        for (int i = 0; i < 8; i++) begin
            r0 = $urandom;
            wr(8'h00, cfg(2'h0, {1'b0, i[0]}, {1'b0, i[1]}, {4'h0, i[2]}, 5'h00));
            src_i <= r0;
            cl((r0[3] ^ i[2]) ? (i[0] ? 2'h2 : 2'h1) : (i[1] ? 2'h2 : 2'h1));
        end
        wr(8'h01, 32'h0);
        wr(8'h00, cfg(2'h0, 2'h1, 2'h0, 5'h1F, 5'h00));
        cl(2'h1);
        $display("test colours done");
        // Flashing pair on one source must stay in step
        wr(8'h01, 32'h02000003);
        wr(8'h05, 32'h02000003);
        wr(8'h04, cfg(2'h0, 2'h3, 2'h0, 5'h00, 5'h00));
        wr(8'h00, cfg(2'h0, 2'h2, 2'h0, 5'h00, 5'h00));
        src_i <= 32'h08;
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        r0 = rises;
        repeat (4 * BH) begin
            @(negedge clk_i);
            chk({31'h0, led_red_o[0] ^ led_green_o[1]}, 32'h0);
        end
        chk(rises - r0, 32'h2);
        @(posedge clk_i);
        en_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        en_i <= 1'b1;
        wr(8'h04, 32'h0);
        $display("test flash done");
        wr(8'h00, cfg(2'h1, 2'h1, 2'h0, 5'h00, 5'h07));
        cl(2'h2);
        src_i <= 32'h00;
        cl(2'h2);
        src_i <= 32'h88;
        cl(2'h2);
        src_i <= 32'h00;
        alarm_ack_i <= 1'b1;
        cl(2'h2);
        alarm_ack_i <= 1'b0;
        src_i <= 32'h80;
        // Latch clears on the acknowledge edge; the colour follows one edge later
        cl(2'h2);
        cl(2'h1);
        $display("test latch done");
        wr(8'h00, cfg(2'h2, 2'h1, 2'h0, 5'h00, 5'h07));
        src_i <= 32'h08;
        cl(2'h2);
        src_i <= 32'h80;
        cl(2'h2);
        alarm_ack_i <= 1'b1;
        cl(2'h2);
        cl(2'h1);
        alarm_ack_i <= 1'b0;
        rd(8'h02, 32'h10);
        $display("test alarm latch done");
        summarize();
    end
endmodule : lal_top_bench
bind lal_top lal_sva #(.N_LED(N_LED), .N_SRC(N_SRC), .BLINK_HALF_CYC(BLINK_HALF_CYC)) u_sva (.clk_i, .rst_b_i,
    .en_i, .src_i, .alarm_ack_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .led_red_o, .led_green_o);
`default_nettype wire
